// ### shared/mit_map.vh
// opcode classes, timing counts and states for the instruction timing block
// How it works
// - plain rotates change no flag, carry rotates only carry; one cycle
// - a write landing in prog_counter_low adds one cycle of four clocks
// - a taken skip adds one cycle of four clocks; no skip, no change
// - incr/decr skip to memory get both skip and counter-load extras
// - jump, call, exits take two cycles and change no flag
// - current or last page fetch: low to memory, high to table_high_byte
// - skip tests cover zero byte, byte copied to acc, and bit 0..7 zero/set
// - incr/decr skip to acc skip on zero result, skip extra only
// - moves and immediate loads take one cycle, no flag change
// - nibble exchange swaps halves into memory or acc, one cycle, no flags
// - byte and bit clear/set take one cycle, no flag change
// - both preclears clear watchdog and flags; a lone one keeps them
// - power-down takes one cycle and may alter expired and powerdown flags
// - halt stops clock, clears watchdog, prescaler, expiry; sets powerdown
// - watchdog_clear zeroes watchdog count and clears both flags
`ifndef MIT_MAP_VH
`define MIT_MAP_VH

`define MIT_OP_W          6
`define MIT_OP_IDLE       6'h00
`define MIT_OP_ROR        6'h01
`define MIT_OP_ROR_A      6'h02
`define MIT_OP_RORC       6'h03
`define MIT_OP_RORC_A     6'h04
`define MIT_OP_ROL        6'h05
`define MIT_OP_ROL_A      6'h06
`define MIT_OP_ROLC       6'h07
`define MIT_OP_ROLC_A     6'h08
`define MIT_OP_XFER_MA    6'h09
`define MIT_OP_XFER_AM    6'h0a
`define MIT_OP_XFER_IA    6'h0b
`define MIT_OP_BIT_CLR    6'h0c
`define MIT_OP_BIT_SET    6'h0d
`define MIT_OP_BYTE_CLR   6'h0e
`define MIT_OP_BYTE_SET   6'h0f
`define MIT_OP_JUMP       6'h10
`define MIT_OP_CALL       6'h11
`define MIT_OP_SUB_EXIT   6'h12
`define MIT_OP_SUB_EXIT_I 6'h13
`define MIT_OP_INT_EXIT   6'h14
`define MIT_OP_SKZ        6'h15
`define MIT_OP_SKZ_A      6'h16
`define MIT_OP_SKB_CLR    6'h17
`define MIT_OP_SKB_SET    6'h18
`define MIT_OP_INC_SKZ    6'h19
`define MIT_OP_DEC_SKZ    6'h1a
`define MIT_OP_INC_SKZ_A  6'h1b
`define MIT_OP_DEC_SKZ_A  6'h1c
`define MIT_OP_TAB_CUR    6'h1d
`define MIT_OP_TAB_LAST   6'h1e
`define MIT_OP_NIB        6'h1f
`define MIT_OP_NIB_A      6'h20
`define MIT_OP_WDT_CLR    6'h21
`define MIT_OP_WDT_PRE1   6'h22
`define MIT_OP_WDT_PRE2   6'h23
`define MIT_OP_PWR_DOWN   6'h24

`define MIT_CLK_PER_CYC   2'd3
`define MIT_CYC_W         2
`define MIT_CYC_ONE       2'd1
`define MIT_CYC_TWO       2'd2
`define MIT_ROM_W         16
`define MIT_ROM_HI        15
`define MIT_ROM_LO        7
`define MIT_ST_IDLE       3'b001
`define MIT_ST_RUN        3'b010
`define MIT_ST_HALT       3'b100

`endif

// ### hw/mit_exec.v
// combinational result, carry and skip decision per opcode class
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.vh"
module mit_exec (
   // instruction
   input  wire [5:0] op,
   input  wire [2:0] bit_idx,
   input  wire [7:0] imm,
   // operands
   input  wire [7:0] mem_rdata,
   input  wire [7:0] acc_in,
   input  wire       carry_in,
   // results
   output reg  [7:0] result,
   output reg        wr_mem,
   output reg        wr_acc,
   output reg        carry_out,
   output reg        carry_we,
   output reg        skip
);
   wire [7:0] bit_sel;
   wire [7:0] inc_val = mem_rdata + 8'h01;
   wire [7:0] dec_val = mem_rdata - 8'h01;

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_sel
         localparam [2:0] IDX = g;
         assign bit_sel[g] = (bit_idx == IDX);
      end
   endgenerate

   // acc-target ops: memory-op variants plus immediate load and immediate exit
   function to_acc;
      input [5:0] o;
      begin
         case (o)
            `MIT_OP_ROR_A, `MIT_OP_RORC_A, `MIT_OP_ROL_A,
            `MIT_OP_ROLC_A, `MIT_OP_XFER_MA, `MIT_OP_XFER_IA,
            `MIT_OP_SKZ_A, `MIT_OP_INC_SKZ_A, `MIT_OP_DEC_SKZ_A,
            `MIT_OP_NIB_A, `MIT_OP_SUB_EXIT_I: to_acc = 1'b1;
            default: to_acc = 1'b0;
         endcase
      end
   endfunction

   always @* begin
      result    = mem_rdata;
      wr_mem    = 1'b0;
      wr_acc    = 1'b0;
      carry_out = carry_in;
      carry_we  = 1'b0;
      skip      = 1'b0;
      case (op)
         `MIT_OP_ROR, `MIT_OP_ROR_A: begin
            result = {mem_rdata[0], mem_rdata[7:1]};
         end
         `MIT_OP_ROL, `MIT_OP_ROL_A: begin
            result = {mem_rdata[6:0], mem_rdata[7]};
         end
         `MIT_OP_RORC, `MIT_OP_RORC_A: begin
            result    = {carry_in, mem_rdata[7:1]};
            carry_out = mem_rdata[0];
            carry_we  = 1'b1;
         end
         `MIT_OP_ROLC, `MIT_OP_ROLC_A: begin
            result    = {mem_rdata[6:0], carry_in};
            carry_out = mem_rdata[7];
            carry_we  = 1'b1;
         end
         `MIT_OP_XFER_AM:    result = acc_in;
         `MIT_OP_XFER_IA:    result = imm;
         `MIT_OP_SUB_EXIT_I: result = imm;
         `MIT_OP_BIT_CLR:    result = mem_rdata & ~bit_sel;
         `MIT_OP_BIT_SET:    result = mem_rdata | bit_sel;
         `MIT_OP_BYTE_CLR:   result = 8'h00;
         `MIT_OP_BYTE_SET:   result = 8'hff;
         `MIT_OP_SKZ, `MIT_OP_SKZ_A: skip = (mem_rdata == 8'h00);
         `MIT_OP_SKB_CLR: skip = ~|(mem_rdata & bit_sel);
         `MIT_OP_SKB_SET: skip = |(mem_rdata & bit_sel);
         `MIT_OP_INC_SKZ, `MIT_OP_INC_SKZ_A: begin
            result = inc_val;
            skip   = (inc_val == 8'h00);
         end
         `MIT_OP_DEC_SKZ, `MIT_OP_DEC_SKZ_A: begin
            result = dec_val;
            skip   = (dec_val == 8'h00);
         end
         `MIT_OP_NIB, `MIT_OP_NIB_A:
            result = {mem_rdata[3:0], mem_rdata[7:4]};
         default: result = mem_rdata;
      endcase
      case (op)
         `MIT_OP_ROR, `MIT_OP_ROL, `MIT_OP_RORC, `MIT_OP_ROLC,
         `MIT_OP_XFER_AM, `MIT_OP_BIT_CLR, `MIT_OP_BIT_SET,
         `MIT_OP_BYTE_CLR, `MIT_OP_BYTE_SET, `MIT_OP_INC_SKZ,
         `MIT_OP_DEC_SKZ, `MIT_OP_NIB: wr_mem = 1'b1;
         default: wr_mem = 1'b0;
      endcase
      wr_acc = to_acc(op) & (op != `MIT_OP_XFER_AM);
      if (to_acc(op))
         wr_mem = 1'b0;
   end
endmodule // mit_exec
`default_nettype wire

// ### hw/mit_cycle_timer.v
// counts instruction cycles of four system clocks each
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.vh"
module mit_cycle_timer (
   // clock and reset
   input  wire       clock,
   input  wire       rst_n,
   // control
   input  wire       start,
   input  wire [1:0] ncyc,
   // status
   output reg        busy,
   output reg        done
);
   reg [1:0] clk_cnt;
   reg [1:0] cyc_left;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy     <= 1'b0;
         done     <= 1'b0;
         clk_cnt  <= 2'd0;
         cyc_left <= 2'd0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy     <= 1'b1;
            clk_cnt  <= 2'd0;
            cyc_left <= ncyc;
         end else if (busy) begin
            clk_cnt <= clk_cnt + 2'd1;
            if (clk_cnt == `MIT_CLK_PER_CYC) begin
               if (cyc_left == `MIT_CYC_ONE) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
               cyc_left <= cyc_left - 2'd1;
            end
         end
      end
   end
endmodule // mit_cycle_timer
`default_nettype wire

// ### hw/mit_instr_timing.v
// instruction timing, flag effects and watchdog/power-down control
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.vh"
module mit_instr_timing (
   // clock and reset
   input  wire        clock,
   input  wire        rst_n,
   // instruction issue
   input  wire        issue,
   input  wire [5:0]  op,
   input  wire [2:0]  bit_idx,
   input  wire [7:0]  imm,
   input  wire        dest_pc_low,
   // operands
   input  wire [7:0]  mem_rdata,
   input  wire [7:0]  acc_in,
   input  wire        carry_in,
   // program memory for table fetch
   input  wire [7:0]  tbl_ptr,
   output reg         rom_req,
   output reg         rom_last_page,
   output reg  [7:0]  rom_addr_lo,
   input  wire        rom_valid,
   input  wire [15:0] rom_word,
   // watchdog and wake
   input  wire        wdt_timeout,
   input  wire        wake,
   // sequencing status
   output wire        busy,
   output reg         retire,
   output reg  [1:0]  cycles_used,
   output reg         skip_next,
   // write-back
   output reg         mem_we,
   output reg  [7:0]  mem_wdata,
   output reg         acc_we,
   output reg  [7:0]  acc_wdata,
   output reg         carry_we,
   output reg         carry_out,
   output reg         tbl_high_we,
   output reg  [7:0]  table_high_byte,
   // watchdog, prescaler, power-down
   output reg         wdt_clear,
   output reg         prescale_clear,
   output reg         halted,
   output reg         clock_stop,
   output reg         watchdog_expired_flag,
   output reg         powerdown_flag
);
   localparam [2:0] ST_IDLE = `MIT_ST_IDLE;
   localparam [2:0] ST_RUN  = `MIT_ST_RUN;
   localparam [2:0] ST_HALT = `MIT_ST_HALT;

   reg  [2:0] state;
   reg  [2:0] next_state;

   // taken instruction
   reg  [5:0] op_q;
   reg  [7:0] res_q;
   reg        wr_mem_q;
   reg        wr_acc_q;
   reg        cy_q;
   reg        cy_we_q;
   reg        skip_q;

   // fetched program word
   reg  [7:0] tab_lo_q;
   reg  [7:0] tab_hi_q;

   // preclear halves seen
   reg        pre1_seen;
   reg        pre2_seen;

   // decoder outputs
   wire [7:0] ex_result;
   wire       ex_wr_mem;
   wire       ex_wr_acc;
   wire       ex_cy;
   wire       ex_cy_we;
   wire       ex_skip;

   // cycle timer status
   wire       tm_busy;
   wire       tm_done;

   // two-cycle classes
   function two_cycle;
      input [5:0] o;
      begin
         case (o)
            `MIT_OP_JUMP, `MIT_OP_CALL, `MIT_OP_SUB_EXIT,
            `MIT_OP_SUB_EXIT_I, `MIT_OP_INT_EXIT,
            `MIT_OP_TAB_CUR, `MIT_OP_TAB_LAST: two_cycle = 1'b1;
            default: two_cycle = 1'b0;
         endcase
      end
   endfunction

   function is_table;
      input [5:0] o;
      begin
         is_table = (o == `MIT_OP_TAB_CUR) || (o == `MIT_OP_TAB_LAST);
      end
   endfunction

   // busy drops issue
   wire take = issue && (state == ST_IDLE);

   // memory writers, table fetch included, pay the counter-load cycle
   wire pcld_pen = dest_pc_low && (ex_wr_mem || is_table(op));
   wire [1:0] base_cyc = two_cycle(op) ? `MIT_CYC_TWO
                                       : `MIT_CYC_ONE;
   wire [1:0] ncyc = base_cyc
                   + {1'b0, pcld_pen}
                   + {1'b0, ex_skip};

   // other half seen earlier
   wire preclear_done =
      ((op_q == `MIT_OP_WDT_PRE1) && pre2_seen) ||
      ((op_q == `MIT_OP_WDT_PRE2) && pre1_seen);

   // act at retire
   wire flag_clear = tm_done && ((op_q == `MIT_OP_WDT_CLR) ||
                                 preclear_done);
   wire enter_halt = tm_done && (op_q == `MIT_OP_PWR_DOWN);

   assign busy = (state != ST_IDLE);

   // decoded at issue
   mit_exec u_exec (
      .op        (op),
      .bit_idx   (bit_idx),
      .imm       (imm),
      .mem_rdata (mem_rdata),
      .acc_in    (acc_in),
      .carry_in  (carry_in),
      .result    (ex_result),
      .wr_mem    (ex_wr_mem),
      .wr_acc    (ex_wr_acc),
      .carry_out (ex_cy),
      .carry_we  (ex_cy_we),
      .skip      (ex_skip)
   );

   // four clocks per cycle
   mit_cycle_timer u_timer (
      .clock (clock),
      .rst_n (rst_n),
      .start (take),
      .ncyc  (ncyc),
      .busy  (tm_busy),
      .done  (tm_done)
   );

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            if (enter_halt)
               next_state = ST_HALT;
            else if (tm_done)
               next_state = ST_IDLE;
         end
         ST_HALT: begin
            // wake only; flags stay
            if (wake)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // issue capture and table fetch
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state         <= ST_IDLE;
         op_q          <= `MIT_OP_IDLE;
         res_q         <= 8'h00;
         wr_mem_q      <= 1'b0;
         wr_acc_q      <= 1'b0;
         cy_q          <= 1'b0;
         cy_we_q       <= 1'b0;
         skip_q        <= 1'b0;
         cycles_used   <= 2'd0;
         rom_req       <= 1'b0;
         rom_last_page <= 1'b0;
         rom_addr_lo   <= 8'h00;
         tab_lo_q      <= 8'h00;
         tab_hi_q      <= 8'h00;
      end else begin
         state   <= next_state;
         rom_req <= 1'b0;
         if (take) begin
            op_q        <= op;
            res_q       <= ex_result;
            wr_mem_q    <= ex_wr_mem;
            wr_acc_q    <= ex_wr_acc;
            cy_q        <= ex_cy;
            cy_we_q     <= ex_cy_we;
            skip_q      <= ex_skip;
            cycles_used <= ncyc;
            if (is_table(op)) begin
               rom_req       <= 1'b1;
               rom_last_page <= (op == `MIT_OP_TAB_LAST);
               rom_addr_lo   <= tbl_ptr;
            end
         end
         // last word wins
         if (rom_valid && (state == ST_RUN) && is_table(op_q)) begin
            tab_lo_q <= rom_word[`MIT_ROM_LO:0];
            tab_hi_q <= rom_word[`MIT_ROM_HI:`MIT_ROM_LO+1];
         end
      end
   end

   // write-back at the end of the last instruction cycle
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         retire          <= 1'b0;
         skip_next       <= 1'b0;
         mem_we          <= 1'b0;
         mem_wdata       <= 8'h00;
         acc_we          <= 1'b0;
         acc_wdata       <= 8'h00;
         carry_we        <= 1'b0;
         carry_out       <= 1'b0;
         tbl_high_we     <= 1'b0;
         table_high_byte <= 8'h00;
      end else begin
         retire      <= tm_done;
         skip_next   <= tm_done && skip_q;
         mem_we      <= 1'b0;
         acc_we      <= 1'b0;
         carry_we    <= 1'b0;
         tbl_high_we <= 1'b0;

         if (tm_done) begin
            if (is_table(op_q)) begin
               mem_we          <= 1'b1;
               mem_wdata       <= tab_lo_q;
               tbl_high_we     <= 1'b1;
               table_high_byte <= tab_hi_q;
            end else begin
               mem_we    <= wr_mem_q;
               mem_wdata <= res_q;
            end
            acc_we    <= wr_acc_q;
            acc_wdata <= res_q;
            carry_we  <= cy_we_q;
            carry_out <= cy_q;
         end
      end
   end

   // watchdog preclear pairing and status flags
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pre1_seen             <= 1'b0;
         pre2_seen             <= 1'b0;
         wdt_clear             <= 1'b0;
         prescale_clear        <= 1'b0;
         halted                <= 1'b0;
         clock_stop            <= 1'b0;
         watchdog_expired_flag <= 1'b0;
         powerdown_flag        <= 1'b0;
      end else begin
         wdt_clear      <= flag_clear || enter_halt;
         prescale_clear <= enter_halt;
         if (flag_clear) begin
            pre1_seen <= 1'b0;
            pre2_seen <= 1'b0;
         end else if (tm_done && op_q == `MIT_OP_WDT_PRE1) begin
            pre1_seen <= 1'b1;
         end else if (tm_done && op_q == `MIT_OP_WDT_PRE2) begin
            pre2_seen <= 1'b1;
         end

         if (enter_halt) begin
            halted     <= 1'b1;
            clock_stop <= 1'b1;
         end else if (state == ST_HALT && wake) begin
            halted     <= 1'b0;
            clock_stop <= 1'b0;
         end

         // a timeout in the clearing cycle still sets the flag
         if (wdt_timeout)
            watchdog_expired_flag <= 1'b1;
         else if (flag_clear || enter_halt)
            watchdog_expired_flag <= 1'b0;
         if (enter_halt)
            powerdown_flag <= 1'b1;
         else if (flag_clear)
            powerdown_flag <= 1'b0;
      end
   end
endmodule // mit_instr_timing
`default_nettype wire

// ### tb/mit_instr_timing_props.sv
// assertions on the instruction timing block ports
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.vh"
module mit_instr_timing_props (
   // clock and reset
   input wire logic       clock, rst_n,
   // issue side
   input wire logic       issue, dest_pc_low,
   input wire logic [5:0] op,
   input wire logic [7:0] tbl_ptr, rom_addr_lo,
   // results
   input wire logic       busy, retire, skip_next, mem_we, carry_we,
   input wire logic       tbl_high_we, wdt_clear, prescale_clear, halted,
   input wire logic       clock_stop, powerdown_flag, rom_req, rom_last_page,
   input wire logic [1:0] cycles_used
);
   logic [4:0] cnt;
   logic [5:0] lop;
   logic       lpcl;
   wire        take;
   wire        lop_acc;
   assign take = issue & ~busy;
   assign lop_acc = lop inside {`MIT_OP_ROR_A, `MIT_OP_RORC_A, `MIT_OP_ROL_A,
      `MIT_OP_ROLC_A, `MIT_OP_SKZ_A, `MIT_OP_INC_SKZ_A, `MIT_OP_DEC_SKZ_A,
      `MIT_OP_NIB_A};
   // clocks since the last take and what was taken
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= 5'h00;
         lop  <= 6'h00;
         lpcl <= 1'b0;
      end else if (take) begin
         cnt  <= 5'h00;
         lop  <= op;
         lpcl <= dest_pc_low;
      end else if (cnt != 5'h1f) begin
         cnt <= cnt + 5'h01;
      end
   end
   default clocking dcb @(posedge clock); endclocking
   default disable iff (!rst_n);
   retire_time_a: assert property (
      retire |-> cnt == {1'b0, cycles_used, 2'b00} + 5'h01)
      else $error("retire not four clocks per cycle");
   branch_cyc_a: assert property (
      retire && lop inside {[`MIT_OP_JUMP:`MIT_OP_INT_EXIT]}
      |-> cycles_used == 2'd2 && !mem_we && !carry_we)
      else $error("branch timing or effect wrong");
   one_cycle_a: assert property (
      retire && lop inside {[`MIT_OP_ROR:`MIT_OP_BYTE_SET], `MIT_OP_NIB_A}
      |-> cycles_used == 2'd1 + {1'b0, lpcl & mem_we} && !skip_next)
      else $error("single cycle op timing wrong");
   acc_skip_a: assert property (
      retire && lop inside {`MIT_OP_INC_SKZ_A, `MIT_OP_DEC_SKZ_A}
      |-> cycles_used == 2'd1 + {1'b0, skip_next})
      else $error("acc skip timing wrong");
   mem_skip_a: assert property (
      retire && lop inside {`MIT_OP_INC_SKZ, `MIT_OP_DEC_SKZ}
      |-> cycles_used == 2'd1 + {1'b0, skip_next} + {1'b0, lpcl})
      else $error("memory skip timing wrong");
   carry_only_a: assert property (
      carry_we |-> retire
      && lop inside {[`MIT_OP_RORC:`MIT_OP_RORC_A], [`MIT_OP_ROLC:`MIT_OP_ROLC_A]})
      else $error("carry written by wrong op");
   acc_keeps_mem_a: assert property (mem_we |-> !lop_acc)
      else $error("acc variant wrote memory");
   table_fetch_a: assert property (
      take && op inside {`MIT_OP_TAB_CUR, `MIT_OP_TAB_LAST} |=> rom_req
      && rom_addr_lo == $past(tbl_ptr)
      && rom_last_page == ($past(op) == `MIT_OP_TAB_LAST))
      else $error("table fetch request wrong");
   table_write_a: assert property (tbl_high_we |-> retire && mem_we)
      else $error("table high byte without memory write");
   halt_entry_a: assert property (
      $rose(halted) |-> clock_stop && prescale_clear && wdt_clear
      && powerdown_flag && retire && busy)
      else $error("power down entry incomplete");
   flag_clear_a: assert property (
      $fell(powerdown_flag) |-> wdt_clear && retire)
      else $error("powerdown flag cleared without watchdog clear");
   skip_pulse_a: assert property (skip_next |-> retire ##1 !skip_next)
      else $error("skip pulse not with retire");
   cover property (retire && cycles_used == 2'd3);
   cover property ($rose(halted));
   cover property (tbl_high_we);
endmodule // mit_instr_timing_props

bind mit_instr_timing mit_instr_timing_props u_props (
   .clock, .rst_n, .issue, .dest_pc_low, .op, .tbl_ptr, .rom_addr_lo, .busy,
   .retire, .skip_next, .mem_we, .carry_we, .tbl_high_we, .wdt_clear,
   .prescale_clear, .halted, .clock_stop, .powerdown_flag, .rom_req,
   .rom_last_page, .cycles_used
);
`default_nettype wire

// ### tb/mit_instr_timing_tb.sv
// self-checking bench for the instruction timing block
`timescale 1ns/100ps
`default_nettype none
`include "mit_map.vh"
module mit_instr_timing_tb;
   typedef struct packed {
      logic [1:0] cyc; logic mw; logic [7:0] md; logic aw; logic [7:0] ad;
      logic cw; logic co; logic sk; logic tw; logic [7:0] th; logic wc;
   } mit_exp_t;
   logic        clock = 1'b0, rst_n = 1'b0, issue = 1'b0, dest_pc_low = 1'b0;
   logic        carry_in = 1'b0, rom_valid = 1'b0, wdt_timeout = 1'b0;
   logic        wake = 1'b0;
   logic [5:0]  op = 6'h00;
   logic [2:0]  bit_idx = 3'h0;
   logic [7:0]  imm = 8'h00, mem_rdata = 8'h00, acc_in = 8'h00;
   logic [7:0]  tbl_ptr = 8'h00, rom_addr_lo, mem_wdata, acc_wdata;
   logic [7:0]  table_high_byte;
   logic [15:0] rom_word = 16'h0000;
   logic [1:0]  cycles_used;
   logic        rom_req, rom_last_page, busy, retire, skip_next, mem_we;
   logic        acc_we, carry_we, carry_out, tbl_high_we, wdt_clear;
   logic        prescale_clear, halted, clock_stop, watchdog_expired_flag;
   logic        powerdown_flag, exp_wx = 1'b0, exp_pd = 1'b0;
   logic        pre1 = 1'b0, pre2 = 1'b0;
   logic [7:0]  mtab [4] = '{8'h00, 8'hff, 8'h01, 8'h5a};
   logic [31:0] r32;
   mit_exp_t    q [$];
   mit_exp_t    got;
   integer      error_cnt = 0, n_tests = 0, seed = 56768, k, rep, n;

   mit_instr_timing u_dut (.clock, .rst_n, .issue, .op, .bit_idx, .imm,
      .dest_pc_low, .mem_rdata, .acc_in, .carry_in, .tbl_ptr, .rom_req,
      .rom_last_page, .rom_addr_lo, .rom_valid, .rom_word, .wdt_timeout,
      .wake, .busy, .retire, .cycles_used, .skip_next, .mem_we, .mem_wdata,
      .acc_we, .acc_wdata, .carry_we, .carry_out, .tbl_high_we,
      .table_high_byte, .wdt_clear, .prescale_clear, .halted, .clock_stop,
      .watchdog_expired_flag, .powerdown_flag);

   always #20 clock = ~clock;
   assign got = {cycles_used, mem_we, mem_we ? mem_wdata : 8'h00, acc_we,
      acc_we ? acc_wdata : 8'h00, carry_we, carry_we & carry_out, skip_next,
      tbl_high_we, tbl_high_we ? table_high_byte : 8'h00, wdt_clear};

   task finish_test;
      $display("mismatches %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task check(input logic [39:0] seen, input logic [39:0] want);
      n_tests = n_tests + 1;
      if (seen !== want) begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, seen, want);
      end
   endtask

   function automatic mit_exp_t predict(input logic [5:0] o,
      input logic [2:0] b, input logic [7:0] x, m, a, input logic c, p,
      input logic [15:0] w);
      mit_exp_t e;
      logic [7:0] r;
      e = '0;
      r = 8'h00;
      case (o)
         `MIT_OP_ROR, `MIT_OP_ROR_A: r = {m[0], m[7:1]};
         `MIT_OP_ROL, `MIT_OP_ROL_A: r = {m[6:0], m[7]};
         `MIT_OP_RORC, `MIT_OP_RORC_A: {r, e.co} = {c, m};
         `MIT_OP_ROLC, `MIT_OP_ROLC_A: {e.co, r} = {m, c};
         `MIT_OP_XFER_MA, `MIT_OP_SKZ_A: r = m;
         `MIT_OP_XFER_AM: r = a;
         `MIT_OP_XFER_IA, `MIT_OP_SUB_EXIT_I: r = x;
         `MIT_OP_BIT_CLR: r = m & ~(8'h01 << b);
         `MIT_OP_BIT_SET: r = m | (8'h01 << b);
         `MIT_OP_BYTE_SET: r = 8'hff;
         `MIT_OP_INC_SKZ, `MIT_OP_INC_SKZ_A: r = m + 8'h01;
         `MIT_OP_DEC_SKZ, `MIT_OP_DEC_SKZ_A: r = m - 8'h01;
         `MIT_OP_NIB, `MIT_OP_NIB_A: r = {m[3:0], m[7:4]};
         `MIT_OP_TAB_CUR, `MIT_OP_TAB_LAST: {e.th, r} = w;
         default: r = 8'h00;
      endcase
      e.cw = o inside {[`MIT_OP_RORC:`MIT_OP_RORC_A],
         [`MIT_OP_ROLC:`MIT_OP_ROLC_A]};
      e.co = e.co & e.cw;
      e.tw = o inside {`MIT_OP_TAB_CUR, `MIT_OP_TAB_LAST};
      e.mw = e.tw || o inside {`MIT_OP_ROR, `MIT_OP_RORC, `MIT_OP_ROL,
         `MIT_OP_ROLC, `MIT_OP_XFER_AM, [`MIT_OP_BIT_CLR:`MIT_OP_BYTE_SET],
         `MIT_OP_INC_SKZ, `MIT_OP_DEC_SKZ, `MIT_OP_NIB};
      e.aw = o inside {`MIT_OP_ROR_A, `MIT_OP_RORC_A, `MIT_OP_ROL_A,
         `MIT_OP_ROLC_A, `MIT_OP_XFER_MA, `MIT_OP_XFER_IA, `MIT_OP_SKZ_A,
         `MIT_OP_SUB_EXIT_I, `MIT_OP_INC_SKZ_A, `MIT_OP_DEC_SKZ_A,
         `MIT_OP_NIB_A};
      if (o inside {`MIT_OP_SKZ, `MIT_OP_SKZ_A}) e.sk = (m == 8'h00);
      if (o == `MIT_OP_SKB_CLR) e.sk = ~m[b];
      if (o == `MIT_OP_SKB_SET) e.sk = m[b];
      if (o inside {[`MIT_OP_INC_SKZ:`MIT_OP_DEC_SKZ_A]}) e.sk = (r == 8'h00);
      e.md = e.mw ? r : 8'h00;
      e.ad = e.aw ? r : 8'h00;
      e.cyc = ((o inside {[`MIT_OP_JUMP:`MIT_OP_INT_EXIT]} || e.tw) ? 2'd2
         : 2'd1) + {1'b0, p & e.mw} + {1'b0, e.sk};
      return e;
   endfunction

   task wait_idle;
      n = 0;
      while (busy !== 1'b0 && n < 200) begin
         @(posedge clock);
         #1;
         n = n + 1;
      end
      if (n == 200) begin
         error_cnt = error_cnt + 1;
         finish_test;
      end
   endtask

   task automatic do_op(input logic [5:0] o, input logic [7:0] m);
      mit_exp_t e;
      logic [31:0] w;
      wait_idle;
      r32 = $random(seed);
      w = $random(seed);
      {imm, acc_in, tbl_ptr, bit_idx, carry_in, dest_pc_low} = r32[28:0];
      op = o;
      mem_rdata = m;
      issue = 1'b1;
      e = predict(o, bit_idx, imm, m, acc_in, carry_in, dest_pc_low, w[15:0]);
      if (o == `MIT_OP_WDT_PRE1) pre1 = 1'b1;
      if (o == `MIT_OP_WDT_PRE2) pre2 = 1'b1;
      if (o == `MIT_OP_WDT_CLR || (pre1 && pre2)) begin
         {e.wc, pre1, pre2, exp_wx, exp_pd} = 5'b10000;
      end
      if (o == `MIT_OP_PWR_DOWN) {e.wc, exp_wx, exp_pd} = 3'b101;
      q.push_back(e);
      @(posedge clock);
      #1;
      issue = 1'b0;
      if (e.tw) begin
         check(40'({rom_req, rom_last_page, rom_addr_lo}),
            40'({1'b1, o == `MIT_OP_TAB_LAST, tbl_ptr}));
         rom_valid = 1'b1;
         rom_word = ~w[15:0];
         @(posedge clock);
         #1;
         rom_word = w[15:0];
         @(posedge clock);
         #1;
         rom_valid = 1'b0;
      end
   endtask

   task flags_chk;
      wait_idle;
      check(40'({watchdog_expired_flag, powerdown_flag}),
         40'({exp_wx, exp_pd}));
   endtask

   task expire;
      wdt_timeout = 1'b1;
      exp_wx = 1'b1;
      @(posedge clock);
      #1;
      wdt_timeout = 1'b0;
   endtask

   // takes the oldest expectation at every retire
   always @(posedge clock) begin
      if (rst_n === 1'b1 && retire === 1'b1) begin
         if (q.size() == 0) check(40'(retire), 40'h0);
         else check(40'(got), 40'(q.pop_front()));
      end
   end

   initial begin
      #(40 * 20000);
      error_cnt = error_cnt + 1;
      finish_test;
   end

   initial begin
      repeat (3) @(posedge clock);
      #1;
      rst_n = 1'b1;
      rom_valid = 1'b1;
      @(posedge clock);
      #1;
      rom_valid = 1'b0;
      for (rep = 0; rep < 8; rep = rep + 1) begin
         r32 = $random(seed);
         mtab[3] = r32[7:0];
         for (k = 1; k <= 32; k = k + 1) do_op(k[5:0], mtab[rep % 4]);
      end
      do_op(`MIT_OP_IDLE, 8'h00);
      @(posedge clock);
      #1;
      op = `MIT_OP_JUMP;
      issue = 1'b1;
      @(posedge clock);
      #1;
      issue = 1'b0;
      wait_idle;
      expire;
      flags_chk;
      do_op(`MIT_OP_WDT_PRE1, 8'h00);
      flags_chk;
      do_op(`MIT_OP_WDT_PRE1, 8'h00);
      flags_chk;
      do_op(`MIT_OP_WDT_PRE2, 8'h00);
      flags_chk;
      expire;
      do_op(`MIT_OP_WDT_PRE2, 8'h00);
      flags_chk;
      do_op(`MIT_OP_WDT_CLR, 8'h00);
      flags_chk;
      expire;
      do_op(`MIT_OP_WDT_PRE1, 8'h00);
      flags_chk;
      do_op(`MIT_OP_PWR_DOWN, 8'h00);
      n = 0;
      while (halted !== 1'b1 && n < 20) begin
         @(posedge clock);
         #1;
         n = n + 1;
      end
      repeat (2) @(posedge clock);
      #1;
      check(40'({halted, clock_stop, busy, watchdog_expired_flag,
         powerdown_flag}), 40'h1d);
      wake = 1'b1;
      wait_idle;
      wake = 1'b0;
      check(40'({halted, clock_stop, powerdown_flag}), 40'h1);
      do_op(`MIT_OP_WDT_PRE2, 8'h00);
      flags_chk;
      repeat (2) @(posedge clock);
      #1;
      check(40'(q.size()), 40'h0);
      finish_test;
   end
endmodule // mit_instr_timing_tb
`default_nettype wire
